// file: isp_defines.vh
// constants of the serial in-system programming engine
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH
`define OP_PROG 8'hac
`define SUB_ENABLE 8'h53
`define SUB_ERASE 8'h80
`define SUB_WR_LFUSE 8'ha0
`define SUB_WR_HFUSE 8'ha8
`define SUB_WR_EFUSE 8'ha4
`define SUB_WR_LOCK 8'he0
`define OP_POLL 8'hf0
`define OP_LOAD_EXT 8'h4d
`define OP_LOAD_HI 8'h48
`define OP_LOAD_LO 8'h40
`define OP_EE_LOAD 8'hc1
`define OP_RD_HI 8'h28
`define OP_RD_LO 8'h20
`define OP_EE_READ 8'ha0
`define OP_RD_FUSE 8'h50
`define OP_RD_LOCK 8'h58
`define SUB_FUSE_ALT 8'h08
`define OP_RD_SIG 8'h30
`define OP_RD_CAL 8'h38
`define OP_WR_PAGE 8'h4c
`define OP_EE_WRITE 8'hc0
`define OP_EE_PAGE 8'hc2
`define ERASED_BYTE 8'hff
`define FUSE_RESET 8'hff
`define CLK_MHZ 40
`define FLASH_WRITE_DELAY_US 4500
`define EEPROM_WRITE_DELAY_US 4000
`define CHIP_ERASE_DELAY_US 4000
`define FUSE_WRITE_DELAY_US 4500
`define FLASH_WRITE_CYCLES (`FLASH_WRITE_DELAY_US * `CLK_MHZ)
`define EEPROM_WRITE_CYCLES (`EEPROM_WRITE_DELAY_US * `CLK_MHZ)
`define CHIP_ERASE_CYCLES (`CHIP_ERASE_DELAY_US * `CLK_MHZ)
`define FUSE_WRITE_CYCLES (`FUSE_WRITE_DELAY_US * `CLK_MHZ)
`endif

// file: isp_engine.v
// serial in-system programming engine: spi slave, instruction decode, memories
// Functional notes
// - eeprom byte write erases then stores
// - eeprom page: load bytes, then commit
// - page commit changes only loaded bytes
// - read returns data in fourth byte
// - reset release ends programming mode
// - four-byte instructions; enable and chip erase
// - poll returns busy flag in bit zero
// - flash page buffer loaded low/high byte
// - extended address byte via 0x4d, stored but not used in addressing
// - flash reads low and high bytes
// - page write commits buffer to flash
// - word addresses, any within page accepted
// - fuse and lock reads by sub-code
// - fuse and lock writes take byte four
// - fuse bits: zero programmed, one unprogrammed
// - echo 0x53 during third enable byte
`include "isp_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module isp_engine #(
   parameter FLASH_AW = 8,
   parameter PAGE_AW = 5,
   parameter EE_AW = 6,
   parameter EE_PAGE_AW = 2,
   parameter [7:0] SIG_BYTE0 = 8'h11,
   parameter [7:0] SIG_BYTE1 = 8'h22,
   parameter [7:0] SIG_BYTE2 = 8'h33,
   parameter [7:0] CAL_BYTE = 8'h80,
   parameter integer FLASH_WRITE_CYCLES = `FLASH_WRITE_CYCLES,
   parameter integer EEPROM_WRITE_CYCLES = `EEPROM_WRITE_CYCLES,
   parameter integer CHIP_ERASE_CYCLES = `CHIP_ERASE_CYCLES,
   parameter integer FUSE_WRITE_CYCLES = `FUSE_WRITE_CYCLES
)(
   // clock, reset, enable
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   // device reset pin, low holds the device in programming
   input wire reset_pin_i,
   // serial link from programmer
   input wire sck_i,
   input wire mosi_i,
   output reg miso_o,
   // status
   output reg prog_mode_o,
   output reg operation_pending_flag_o
);
   // signature bytes and calibration byte above are arbitrary neutral values
   reg [2:0] sck_s;
   reg [2:0] mosi_s;
   reg [2:0] rst_s;
   reg [2:0] bit_cnt;
   reg [1:0] byte_cnt;
   reg [7:0] shift_in;
   reg [7:0] shift_out;
   reg [7:0] b1, b2, b3;
   reg enabled_reg;
   reg [31:0] busy_cnt;
   reg [7:0] ext_addr;
   reg [7:0] lfuse, hfuse, efuse, lock_bits;
   reg [15:0] flash_mem [0:(1<<FLASH_AW)-1];
   reg [15:0] page_buf [0:(1<<PAGE_AW)-1];
   reg [1:0] page_ld [0:(1<<PAGE_AW)-1];
   reg [7:0] ee_mem [0:(1<<EE_AW)-1];
   reg [7:0] ee_buf [0:(1<<EE_PAGE_AW)-1];
   reg ee_ld [0:(1<<EE_PAGE_AW)-1];
   reg [7:0] rd_byte;
   integer i;
   reg sck_f;
   reg pin_f;

   // a pin change counts once stages two and three agree
   wire sck_agree = (sck_s[1] == sck_s[2]);
   wire pin_agree = (rst_s[1] == rst_s[2]);
   wire sck_rise = sck_agree & sck_s[2] & ~sck_f;
   wire sck_fall = sck_agree & ~sck_s[2] & sck_f;
   wire in_reset = ~pin_f;
   wire [7:0] byte4 = {shift_in[6:0], mosi_s[1]};
   // the third byte is still in the shifter when a read is set up
   wire [7:0] lsb = (byte_cnt == 2'h2) ? byte4 : b3;
   wire [15:0] waddr = {b2, lsb};
   wire [FLASH_AW-1:0] faddr = waddr[FLASH_AW-1:0];
   wire [PAGE_AW-1:0] paddr = waddr[PAGE_AW-1:0];

   // byte returned during the fourth byte
   always @*
   begin
      rd_byte = 8'h00;
      if (b1 == `OP_POLL)
         rd_byte = {7'h00, operation_pending_flag_o};
      else if (b1 == `OP_RD_LO)
         rd_byte = flash_mem[faddr][7:0];
      else if (b1 == `OP_RD_HI)
         rd_byte = flash_mem[faddr][15:8];
      else if (b1 == `OP_EE_READ)
         rd_byte = ee_mem[lsb[EE_AW-1:0]];
      else if (b1 == `OP_RD_FUSE)
         rd_byte = (b2 == `SUB_FUSE_ALT) ? efuse : lfuse;
      else if (b1 == `OP_RD_LOCK)
         rd_byte = (b2 == `SUB_FUSE_ALT) ? hfuse : lock_bits;
      else if (b1 == `OP_RD_SIG)
      begin
         if (lsb[1:0] == 2'h0)
            rd_byte = SIG_BYTE0;
         else if (lsb[1:0] == 2'h1)
            rd_byte = SIG_BYTE1;
         else
            rd_byte = SIG_BYTE2;
      end
      else if (b1 == `OP_RD_CAL)
         rd_byte = CAL_BYTE;
   end
   // pin synchronisers and filtered levels
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sck_s <= 3'h0;
         mosi_s <= 3'h0;
         rst_s <= 3'h7;
         sck_f <= 1'b0;
         pin_f <= 1'b1;
      end
      else if (ce_i)
      begin
         sck_s <= {sck_s[1:0], sck_i};
         mosi_s <= {mosi_s[1:0], mosi_i};
         rst_s <= {rst_s[1:0], reset_pin_i};
         if (sck_agree)
            sck_f <= sck_s[2];
         if (pin_agree)
            pin_f <= rst_s[2];
      end
   end

   // status outputs
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prog_mode_o <= 1'b0;
         operation_pending_flag_o <= 1'b0;
      end
      else if (ce_i)
      begin
         prog_mode_o <= enabled_reg;
         operation_pending_flag_o <= (busy_cnt != 32'h0);
      end
   end

   // framing, decode and execution
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         bit_cnt <= 3'h0;
         byte_cnt <= 2'h0;
         shift_in <= 8'h00;
         shift_out <= 8'h00;
         b1 <= 8'h00;
         b2 <= 8'h00;
         b3 <= 8'h00;
         enabled_reg <= 1'b0;
         busy_cnt <= 32'h0;
         ext_addr <= 8'h00;
         lfuse <= `FUSE_RESET;
         hfuse <= `FUSE_RESET;
         efuse <= `FUSE_RESET;
         lock_bits <= `FUSE_RESET;
         miso_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (busy_cnt != 32'h0)
            busy_cnt <= busy_cnt - 32'h1;
         if (!in_reset)
         begin
            // releasing reset leaves programming mode
            enabled_reg <= 1'b0;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
            miso_o <= 1'b0;
         end
         else
         begin
            if (sck_fall)
            begin
               miso_o <= shift_out[7];
               shift_out <= {shift_out[6:0], 1'b0};
            end
            if (sck_rise)
            begin
               shift_in <= byte4;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7)
               begin
                  byte_cnt <= byte_cnt + 2'h1;
                  shift_out <= 8'h00;
                  if (byte_cnt == 2'h0)
                     b1 <= byte4;
                  else if (byte_cnt == 2'h1)
                  begin
                     b2 <= byte4;
                     if (b1 == `OP_PROG && byte4 == `SUB_ENABLE)
                        shift_out <= byte4;
                  end
                  else if (byte_cnt == 2'h2)
                  begin
                     b3 <= byte4;
                     if (enabled_reg)
                        shift_out <= rd_byte;
                  end
                  else
                  begin
                     if (b1 == `OP_PROG && b2 == `SUB_ENABLE)
                        enabled_reg <= 1'b1;
                     else if (enabled_reg && busy_cnt == 32'h0)
                     begin
                        if (b1 == `OP_PROG && b2 == `SUB_ERASE)
                        begin
                           for (i = 0; i < (1<<FLASH_AW); i = i + 1)
                              flash_mem[i] <= {`ERASED_BYTE, `ERASED_BYTE};
                           for (i = 0; i < (1<<EE_AW); i = i + 1)
                              ee_mem[i] <= `ERASED_BYTE;
                           lock_bits <= `FUSE_RESET;
                           busy_cnt <= CHIP_ERASE_CYCLES;
                        end
                        else if (b1 == `OP_PROG)
                        begin
                           // fuses stored as given, lock bits ANDed with the old value: zero programmed, one unprogrammed
                           if (b2 == `SUB_WR_LFUSE)
                              lfuse <= byte4;
                           else if (b2 == `SUB_WR_HFUSE)
                              hfuse <= byte4;
                           else if (b2 == `SUB_WR_EFUSE)
                              efuse <= byte4;
                           else if (b2 == `SUB_WR_LOCK)
                              lock_bits <= lock_bits & byte4;
                           busy_cnt <= FUSE_WRITE_CYCLES;
                        end
                        else if (b1 == `OP_LOAD_EXT)
                           ext_addr <= b3;
                        else if (b1 == `OP_LOAD_LO)
                        begin
                           page_buf[paddr][7:0] <= byte4;
                           page_ld[paddr][0] <= 1'b1;
                        end
                        else if (b1 == `OP_LOAD_HI)
                        begin
                           page_buf[paddr][15:8] <= byte4;
                           page_ld[paddr][1] <= 1'b1;
                        end
                        else if (b1 == `OP_WR_PAGE)
                        begin
                           // low page bits ignored: any word of the page selects it
                           for (i = 0; i < (1<<PAGE_AW); i = i + 1)
                           begin
                              if (page_ld[i][0])
                                 flash_mem[{faddr[FLASH_AW-1:PAGE_AW], i[PAGE_AW-1:0]}][7:0] <= page_buf[i][7:0];
                              if (page_ld[i][1])
                                 flash_mem[{faddr[FLASH_AW-1:PAGE_AW], i[PAGE_AW-1:0]}][15:8] <= page_buf[i][15:8];
                              page_ld[i] <= 2'h0;
                           end
                           busy_cnt <= FLASH_WRITE_CYCLES;
                        end
                        else if (b1 == `OP_EE_WRITE)
                        begin
                           // self-timed erase then write, no chip erase needed
                           ee_mem[b3[EE_AW-1:0]] <= byte4;
                           busy_cnt <= EEPROM_WRITE_CYCLES;
                        end
                        else if (b1 == `OP_EE_LOAD)
                        begin
                           ee_buf[b3[EE_PAGE_AW-1:0]] <= byte4;
                           ee_ld[b3[EE_PAGE_AW-1:0]] <= 1'b1;
                        end
                        else if (b1 == `OP_EE_PAGE)
                        begin
                           for (i = 0; i < (1<<EE_PAGE_AW); i = i + 1)
                           begin
                              if (ee_ld[i])
                                 ee_mem[{b3[EE_AW-1:EE_PAGE_AW], i[EE_PAGE_AW-1:0]}] <= ee_buf[i];
                              ee_ld[i] <= 1'b0;
                           end
                           busy_cnt <= EEPROM_WRITE_CYCLES;
                        end
                     end
                  end
               end
            end
         end
      end
   end

endmodule
`default_nettype wire

// file: isp_engine_asserts.sv
// concurrent checks on the ports of the serial programming engine
`timescale 1ns/1ps
`default_nettype none
module isp_engine_asserts #(
   parameter integer FLASH_WRITE_CYCLES = 1,
   parameter integer EEPROM_WRITE_CYCLES = 1,
   parameter integer CHIP_ERASE_CYCLES = 1,
   parameter integer FUSE_WRITE_CYCLES = 1
)(
   // clock and reset
   input wire clk_i,
   input wire rstn_i,
   input wire ce_i,
   // link and pin
   input wire reset_pin_i,
   input wire sck_i,
   input wire mosi_i,
   input wire miso_o,
   // status
   input wire prog_mode_o,
   input wire operation_pending_flag_o
);
   integer busy_cnt;
   always @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         busy_cnt <= 0;
      else
         busy_cnt <= operation_pending_flag_o ? busy_cnt + 1 : 0;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_pin_off;
      (reset_pin_i && ce_i) [*8];
   endsequence
   sequence s_sck_high;
      sck_i [*3];
   endsequence
   a_release_quiet: assert property ($rose(rstn_i) |-> !prog_mode_o && !operation_pending_flag_o && !miso_o)
      else $error("outputs not idle after reset");
   a_pin_ends_mode: assert property (s_pin_off |-> !prog_mode_o)
      else $error("programming mode kept with pin high");
   a_mode_holds: assert property (prog_mode_o && !reset_pin_i |=> prog_mode_o)
      else $error("programming mode dropped");
   a_mode_needs_pin: assert property ($rose(prog_mode_o) |-> !$past(reset_pin_i, 8) && !sck_i)
      else $error("programming mode entered wrongly");
   a_busy_after_frame: assert property ($rose(operation_pending_flag_o) |-> prog_mode_o && !sck_i)
      else $error("busy raised outside a finished instruction");
   a_busy_length: assert property ($fell(operation_pending_flag_o) |->
      busy_cnt >= EEPROM_WRITE_CYCLES - 1 && busy_cnt <= FUSE_WRITE_CYCLES + 1)
      else $error("busy length wrong");
   a_miso_at_fall: assert property ($fell(sck_i) |-> $stable(miso_o) [*2])
      else $error("serial out changed too early");
   a_miso_high: assert property (s_sck_high |-> $stable(miso_o))
      else $error("serial out changed while clock high");
endmodule
bind isp_engine isp_engine_asserts #(.FLASH_WRITE_CYCLES(FLASH_WRITE_CYCLES), .EEPROM_WRITE_CYCLES(EEPROM_WRITE_CYCLES),
   .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES), .FUSE_WRITE_CYCLES(FUSE_WRITE_CYCLES)) i_isp_engine_asserts (
   .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reset_pin_i(reset_pin_i), .sck_i(sck_i), .mosi_i(mosi_i),
   .miso_o(miso_o), .prog_mode_o(prog_mode_o), .operation_pending_flag_o(operation_pending_flag_o));
`default_nettype wire

// file: isp_programmer.sv
// programmer model: master of the serial link and of the reset pin
`timescale 1ns/1ps
`default_nettype none
module isp_programmer (
   // clock
   input wire logic clk_i,
   // link
   output logic sck_o,
   output logic mosi_o,
   output logic reset_pin_o,
   input wire logic miso_i
);
   initial
   begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
      reset_pin_o = 1'b0;
   end
   // one instruction, msb first; clock stands low between frames
   task automatic frame(input logic [31:0] ins, output logic [31:0] got);
      for (int i = 31; i >= 0; i--)
      begin
         mosi_o = ins[i];
         repeat (4) @(negedge clk_i);
         sck_o = 1'b1;
         repeat (4) @(negedge clk_i);
         got[i] = miso_i;
         sck_o = 1'b0;
      end
      // let the device act on the last bit before anyone looks
      repeat (8) @(negedge clk_i);
      mosi_o = ~mosi_o;
   endtask
   // polling replaces the fixed write delays
   task automatic wait_ready(output logic [7:0] st);
      logic [31:0] g;
      st = 8'h01;
      for (int n = 0; n < 8 && st[0] !== 1'b0; n++)
      begin
         frame(32'hf0000000, g);
         st = g[7:0];
      end
   endtask
   task automatic pin(input logic v);
      reset_pin_o = v;
   endtask
endmodule
`default_nettype wire

// file: tb_serial_isp_memory_programming.sv
// self-checking bench for the serial programming engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_serial_isp_memory_programming;
   logic clk_i, rstn_i, ce, sck, mosi, pin, miso, mode, busy;
   int errors = 0, tests_run = 0, cyc = 0;
   logic [31:0] g;
   logic [7:0] st, a, d, v, p0, p2;
   logic [7:0] e [4];
   logic [15:0] rdc [4] = '{16'h5000, 16'h5808, 16'h5008, 16'h5800};
   logic [7:0] wrc [4] = '{8'ha0, 8'ha8, 8'ha4, 8'he0};
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   isp_engine #(.FLASH_WRITE_CYCLES(450), .EEPROM_WRITE_CYCLES(400), .CHIP_ERASE_CYCLES(400),
      .FUSE_WRITE_CYCLES(450)) i_isp_engine (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .reset_pin_i(pin),
      .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .prog_mode_o(mode), .operation_pending_flag_o(busy));
   isp_programmer i_isp_programmer (.clk_i(clk_i), .sck_o(sck), .mosi_o(mosi), .reset_pin_o(pin), .miso_i(miso));
   task results;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         errors++;
         results;
      end
   end
   task automatic fr(input logic [31:0] ins);
      i_isp_programmer.frame(ins, g);
   endtask
   task automatic rd(input logic [31:0] ins, input logic [7:0] x);
      fr(ins);
      `CHK("read", x, g[7:0])
   endtask
   initial
   begin
      rstn_i = 1'b0;
      ce = 1'b1;
      void'($urandom(32'h7e79));
      repeat (4) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      fr(32'hc0000512);
      `CHK("busy", 1'b0, busy)
      fr(32'hac530000);
      `CHK("echo", 8'h53, g[15:8])
      `CHK("mode", 1'b1, mode)
      fr(32'hac800000);
      fr(32'hf0000000);
      `CHK("poll", 8'h01, g[7:0])
      i_isp_programmer.wait_ready(st);
      `CHK("ready", 8'h00, st)
      a = 8'($urandom);
      rd({8'h20, 8'h00, a, 8'h00}, 8'hff);
      rd({8'h28, 8'h00, a, 8'h00}, 8'hff);
      for (int k = 0; k < 4; k++)
      begin
         rd({rdc[k], 16'h0000}, 8'hff);
         v = 8'($urandom);
         fr({8'hac, wrc[k], 8'h00, v});
         i_isp_programmer.wait_ready(st);
         rd({rdc[k], 16'h0000}, v);
      end
      a = {2'b00, 6'($urandom)};
      a[1:0] = 2'b01;
      for (int n = 0; n < 2; n++)
      begin
         d = 8'($urandom);
         fr({8'hc0, 8'h00, a, d});
         fr({8'hc0, 8'h00, a ^ 8'h02, 8'h3c});
         i_isp_programmer.wait_ready(st);
         rd({8'ha0, 8'h00, a ^ 8'h02, 8'h00}, 8'hff);
         rd({8'ha0, 8'h00, a, 8'h00}, d);
      end
      p0 = 8'($urandom);
      p2 = 8'($urandom);
      fr({8'hc1, 8'h00, 8'h00, p0});
      fr({8'hc1, 8'h00, 8'h02, p2});
      fr({8'hc2, 8'h00, a[7:2], 2'b00, 8'h00});
      i_isp_programmer.wait_ready(st);
      e = '{p0, d, p2, 8'hff};
      for (int j = 0; j < 4; j++)
         rd({8'ha0, 8'h00, a[7:2], 2'(j), 8'h00}, e[j]);
      a = 8'($urandom);
      d = 8'($urandom);
      v = 8'($urandom);
      fr(32'h4d000000);
      fr({8'h40, 8'h00, a, d});
      fr({8'h48, 8'h00, a, v});
      fr({8'h4c, 8'h00, a ^ 8'h15, 8'h00});
      i_isp_programmer.wait_ready(st);
      rd({8'h20, 8'h00, a, 8'h00}, d);
      rd({8'h28, 8'h00, a, 8'h00}, v);
      ce = 1'b0;
      i_isp_programmer.pin(1'b1);
      repeat (16) @(negedge clk_i);
      `CHK("frozen", 1'b1, mode)
      ce = 1'b1;
      repeat (16) @(negedge clk_i);
      `CHK("mode", 1'b0, mode)
      results;
   end
endmodule
`default_nettype wire
